// ---- wds_defines.vh ----
`ifndef WDS_DEFINES_VH
`define WDS_DEFINES_VH
// Register byte addresses (printed offsets are not all multiples of four: index times four)
`define WDS_IDX_INTCTL 8'h0B
`define WDS_IDX_PFLAG 8'h0C
`define WDS_IDX_PEN 8'h8C
`define WDS_IDX_OPTION 8'h81
`define WDS_IDX_STATUS 8'h83
`define WDS_IDX_CTRL 8'h90
`define WDS_ADDR_INTCTL 12'h02C
`define WDS_ADDR_PFLAG 12'h030
`define WDS_ADDR_PEN 12'h230
`define WDS_ADDR_OPTION 12'h204
`define WDS_ADDR_STATUS 12'h20C
`define WDS_ADDR_CTRL 12'h240
// Field positions
`define WDS_INT_GIE 7
`define WDS_INT_PEIE 6
`define WDS_INT_T0IE 5
`define WDS_INT_EXTIE 4
`define WDS_INT_RBIE 3
`define WDS_INT_T0IF 2
`define WDS_INT_EXTIF 1
`define WDS_INT_RBIF 0
`define WDS_PER_CMP 6
`define WDS_OPT_PSA 3
`define WDS_ST_TO 4
`define WDS_ST_PD 3
`define WDS_CTL_CLEAR_WATCHDOG_INSTR 0
`define WDS_CTL_SLEEP 1
// Reset values
`define WDS_RST_INTCTL 8'h00
`define WDS_RST_PFLAG 8'h00
`define WDS_RST_PEN 8'h00
`define WDS_RST_OPTION 8'hFF
// Timing
`define WDS_WDT_PERIOD_US 18000
`define WDS_RC_PERIOD_NS 1000
`define WDS_CLK_PERIOD_NS 10
`define WDS_OST_TOSC 1024
`define WDS_TOSC_NS 250
`define WDS_AXI_OKAY 2'b00
`define WDS_AXI_SLVERR 2'b10
`endif

// ---- wds_watchdog_sleep.v ----
`include "wds_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module wds_watchdog_sleep #(
  parameter integer WDT_BASE_TICKS = (`WDS_WDT_PERIOD_US * 1000) / `WDS_RC_PERIOD_NS,
  parameter integer OST_CYCLES = (`WDS_OST_TOSC * `WDS_TOSC_NS) / `WDS_CLK_PERIOD_NS,
  parameter integer PORT_W = 13
) (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rc_tick,
  input wire watchdog_fuse_enable,
  input wire osc_mode_rc,
  input wire master_clear_pin_n,
  input wire clear_watchdog_instr,
  input wire sleep_instr,
  input wire ext_interrupt_evt,
  input wire port_change_evt,
  input wire timer_overflow_evt,
  input wire comparator_evt,
  input wire [PORT_W-1:0] port_out_core,
  input wire [PORT_W-1:0] port_oe_core,
  output reg [PORT_W-1:0] port_out,
  output reg [PORT_W-1:0] port_oe,
  output reg device_reset,
  output reg osc_run,
  output reg core_stall,
  output reg prefetch_next,
  output reg resume_pulse,
  output reg irq_vector
);
  localparam [1:0] ST_RUN = 2'd0;
  localparam [1:0] ST_SLEEP = 2'd1;
  localparam [1:0] ST_OST = 2'd2;
  localparam [1:0] ST_RESUME = 2'd3;
  localparam [23:0] BASE_TICKS = WDT_BASE_TICKS[23:0];
  localparam [15:0] OST_LEN = OST_CYCLES[15:0];

  reg [1:0] state_q;
  reg [7:0] intctl_q;
  reg [7:0] pflag_q;
  reg [7:0] pen_q;
  reg [7:0] option_q;
  reg to_flag_q;
  reg pd_flag_q;
  reg [23:0] wdt_cnt_q;
  reg [6:0] presc_q;
  reg [15:0] ost_cnt_q;
  reg irq_wake_q;
  reg aw_hold_q;
  reg w_hold_q;
  reg [11:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog prescaler and time-out
  wire wdt_on = watchdog_fuse_enable;
  wire psa_wdt = option_q[`WDS_OPT_PSA];
  reg [6:0] presc_mask;
  always @* begin
    case (option_q[2:0])
      3'd0: presc_mask = 7'h00;
      3'd1: presc_mask = 7'h01;
      3'd2: presc_mask = 7'h03;
      3'd3: presc_mask = 7'h07;
      3'd4: presc_mask = 7'h0F;
      3'd5: presc_mask = 7'h1F;
      3'd6: presc_mask = 7'h3F;
      default: presc_mask = 7'h7F; // Ratio 1:128
    endcase
  end
  // Prescaled tick: one per ratio RC ticks, or every tick if prescaler is with the timer
  wire presc_done = !psa_wdt || ((presc_q & presc_mask) == presc_mask);
  wire wdt_step = wdt_on && rc_tick && presc_done;
  wire wdt_timeout = wdt_step && (wdt_cnt_q == BASE_TICKS - 24'h000001);
  wire do_sleep = (state_q == ST_RUN) && sleep_instr;
  wire do_clr = (state_q == ST_RUN) && clear_watchdog_instr;
  ////////////////////////////////////////////////////////////////////////////////
  // Wake sources
  wire ext_pend = intctl_q[`WDS_INT_EXTIE] && (intctl_q[`WDS_INT_EXTIF] || ext_interrupt_evt);
  wire rb_pend = intctl_q[`WDS_INT_RBIE] && (intctl_q[`WDS_INT_RBIF] || port_change_evt);
  wire per_pend = intctl_q[`WDS_INT_PEIE] && pen_q[`WDS_PER_CMP]
    && (pflag_q[`WDS_PER_CMP] || comparator_evt);
  wire irq_pend = ext_pend || rb_pend || per_pend; // Global enable not consulted
  wire master_clear_pin_low = !master_clear_pin_n;
  wire bus_wr_go;
  wire [11:0] wr_addr;
  wire [31:0] wr_data;
  assign bus_wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  wire wr_lane0 = bus_wr_go && wstrb_q[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Sleep / wake sequencer and watchdog counter
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_RUN;
      wdt_cnt_q <= 24'h000000;
      presc_q <= 7'h00;
      ost_cnt_q <= 16'h0000;
      to_flag_q <= 1'b1;
      pd_flag_q <= 1'b1;
      irq_wake_q <= 1'b0;
      device_reset <= 1'b0;
      osc_run <= 1'b1;
      core_stall <= 1'b0;
      prefetch_next <= 1'b0;
      resume_pulse <= 1'b0;
      irq_vector <= 1'b0;
    end else begin
      device_reset <= 1'b0;
      prefetch_next <= 1'b0;
      resume_pulse <= 1'b0;
      irq_vector <= 1'b0;
      if (do_clr || do_sleep) begin
        wdt_cnt_q <= 24'h000000;
        if (psa_wdt) presc_q <= 7'h00;
      end else if (wdt_timeout) begin
        wdt_cnt_q <= 24'h000000;
        presc_q <= 7'h00;
      end else if (wdt_on && rc_tick) begin
        if (psa_wdt) presc_q <= presc_q + 7'h01;
        if (presc_done) wdt_cnt_q <= wdt_cnt_q + 24'h000001;
      end
      if (wdt_timeout) to_flag_q <= 1'b0;
      if (do_clr) begin
        to_flag_q <= 1'b1;
        pd_flag_q <= 1'b1;
      end
      case (state_q)
        ST_RUN: begin
          if (master_clear_pin_low) begin
            device_reset <= 1'b1;
            pd_flag_q <= 1'b1;
          end else if (wdt_timeout && !do_clr && !do_sleep) begin
            device_reset <= 1'b1; // Internal only, pin is input
          end else if (do_sleep) begin
            pd_flag_q <= 1'b0;
            to_flag_q <= 1'b1;
            prefetch_next <= 1'b1;
            core_stall <= 1'b1;
            if (irq_pend) begin
              irq_wake_q <= 1'b1; // Sleep completes, then wakes at once
              state_q <= ST_RESUME;
            end else begin
              osc_run <= 1'b0;
              state_q <= ST_SLEEP;
            end
          end
        end
        ST_SLEEP: begin
          if (master_clear_pin_low) begin
            device_reset <= 1'b1;
            osc_run <= 1'b1;
            core_stall <= 1'b0;
            state_q <= ST_RUN;
          end else if (wdt_timeout || irq_pend) begin
            irq_wake_q <= irq_pend && !wdt_timeout;
            wdt_cnt_q <= 24'h000000;
            presc_q <= 7'h00;
            osc_run <= 1'b1;
            ost_cnt_q <= 16'h0000;
            state_q <= osc_mode_rc ? ST_RESUME : ST_OST;
          end
        end
        ST_OST: begin
          if (master_clear_pin_low) begin
            device_reset <= 1'b1;
            core_stall <= 1'b0;
            state_q <= ST_RUN;
          end else if (ost_cnt_q == OST_LEN - 16'h0001) begin
            state_q <= ST_RESUME;
          end else begin
            ost_cnt_q <= ost_cnt_q + 16'h0001;
          end
        end
        default: begin
          // Continue in line; vector only when globally enabled
          wdt_cnt_q <= 24'h000000;
          resume_pulse <= 1'b1;
          irq_vector <= irq_wake_q && intctl_q[`WDS_INT_GIE];
          irq_wake_q <= 1'b0;
          core_stall <= 1'b0;
          state_q <= ST_RUN;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Port drive follows the core only while running; the start-up wait keeps the sleep state,
  // since the core is still stalled and cannot have meant a new drive value
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi = gi + 1) begin : g_port
      always @(posedge aclk) begin
        if (!aresetn) begin
          port_out[gi] <= 1'b0;
          port_oe[gi] <= 1'b0;
        end else if (state_q == ST_RUN) begin
          port_out[gi] <= port_out_core[gi];
          port_oe[gi] <= port_oe_core[gi];
        end
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt flags: event set beats software clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      intctl_q <= `WDS_RST_INTCTL;
      pflag_q <= `WDS_RST_PFLAG;
      pen_q <= `WDS_RST_PEN;
      option_q <= `WDS_RST_OPTION;
    end else begin
      if (wr_lane0 && wr_addr == `WDS_ADDR_INTCTL) intctl_q <= wr_data[7:0];
      if (wr_lane0 && wr_addr == `WDS_ADDR_PFLAG) pflag_q <= wr_data[7:0] & 8'h40;
      if (wr_lane0 && wr_addr == `WDS_ADDR_PEN) pen_q <= wr_data[7:0] & 8'h40;
      if (wr_lane0 && wr_addr == `WDS_ADDR_OPTION) option_q <= wr_data[7:0];
      if (ext_interrupt_evt) intctl_q[`WDS_INT_EXTIF] <= 1'b1;
      if (port_change_evt) intctl_q[`WDS_INT_RBIF] <= 1'b1;
      if (timer_overflow_evt) intctl_q[`WDS_INT_T0IF] <= 1'b1;
      if (comparator_evt) pflag_q[`WDS_PER_CMP] <= 1'b1;
      if (state_q == ST_RESUME && irq_wake_q && intctl_q[`WDS_INT_GIE]) intctl_q[`WDS_INT_GIE] <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data taken in either order, response once both held
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WDS_AXI_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `WDS_AXI_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (bus_wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr == `WDS_ADDR_INTCTL || wr_addr == `WDS_ADDR_PFLAG ||
          wr_addr == `WDS_ADDR_PEN || wr_addr == `WDS_ADDR_OPTION ||
          wr_addr == `WDS_ADDR_STATUS || wr_addr == `WDS_ADDR_CTRL) ? `WDS_AXI_OKAY : `WDS_AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `WDS_AXI_OKAY;
        if ({s_axi_araddr[11:2], 2'b00} == `WDS_ADDR_INTCTL) s_axi_rdata <= {24'h000000, intctl_q};
        else if ({s_axi_araddr[11:2], 2'b00} == `WDS_ADDR_PFLAG) s_axi_rdata <= {24'h000000, pflag_q};
        else if ({s_axi_araddr[11:2], 2'b00} == `WDS_ADDR_PEN) s_axi_rdata <= {24'h000000, pen_q};
        else if ({s_axi_araddr[11:2], 2'b00} == `WDS_ADDR_OPTION) s_axi_rdata <= {24'h000000, option_q};
        else if ({s_axi_araddr[11:2], 2'b00} == `WDS_ADDR_STATUS)
          s_axi_rdata <= {27'h0000000, to_flag_q, pd_flag_q, 3'b000};
        else if ({s_axi_araddr[11:2], 2'b00} == `WDS_ADDR_CTRL)
          s_axi_rdata <= {30'h00000000, state_q == ST_OST, state_q == ST_SLEEP};
        else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `WDS_AXI_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // wds_watchdog_sleep
`default_nettype wire

// ---- wds_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module wds_core_model #(
  parameter integer TICK_DIV = 4
) (
  input wire logic aclk,
  output var logic rc_tick
);
  // Free-running: ignores reset and sleep, as the separate oscillator does
  int cnt = 0;
  initial rc_tick = 1'h0;
  always @(posedge aclk) begin
    cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
    rc_tick <= (cnt == TICK_DIV - 1);
  end
endmodule // wds_core_model
`default_nettype wire

// ---- wds_watchdog_sleep_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module wds_checker #(
  parameter integer OST_CYCLES = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire watchdog_fuse_enable,
  input wire osc_mode_rc,
  input wire master_clear_pin_n,
  input wire clear_watchdog_instr,
  input wire sleep_instr,
  input wire [12:0] port_out,
  input wire [12:0] port_oe,
  input wire device_reset,
  input wire osc_run,
  input wire core_stall,
  input wire prefetch_next,
  input wire resume_pulse,
  input wire irq_vector
);
  // Slack covers the registered hand-off around the start-up count
  localparam int OST_LO = OST_CYCLES - 1;
  localparam int OST_HI = OST_CYCLES + 3;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  sequence s_enter;
    sleep_instr && !core_stall && master_clear_pin_n;
  endsequence
  sequence s_start;
    $rose(osc_run) && master_clear_pin_n && $past(master_clear_pin_n);
  endsequence
  a_sleep_entry: assert property (s_enter |=> core_stall && prefetch_next)
    else $error("sleep entry not stalled");
  a_prefetch_cause: assert property (prefetch_next |-> $past(sleep_instr) && !$past(core_stall))
    else $error("prefetch without sleep");
  a_ports_frozen: assert property (core_stall && $past(core_stall) && master_clear_pin_n
    |-> $stable(port_out) && $stable(port_oe))
    else $error("port drive moved in sleep");
  a_vector_resume: assert property (irq_vector |-> resume_pulse)
    else $error("vector without resume");
  a_xtal_start: assert property (s_start ##0 !osc_mode_rc |-> ##[OST_LO:OST_HI] resume_pulse)
    else $error("start-up wait wrong");
  a_rc_start: assert property (s_start ##0 osc_mode_rc |-> ##[0:2] resume_pulse)
    else $error("rc mode waited");
  a_fuse_off: assert property (!watchdog_fuse_enable && master_clear_pin_n && $past(master_clear_pin_n)
    && $past(master_clear_pin_n, 2) |-> !device_reset)
    else $error("reset with watchdog fused off");
  a_clear_holds: assert property (clear_watchdog_instr && master_clear_pin_n |=> !device_reset [*8])
    else $error("reset right after clear");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // wds_checker
bind wds_watchdog_sleep wds_checker #(.OST_CYCLES(OST_CYCLES)) i_chk (.*);
`default_nettype wire

// ---- tb_watchdog_sleep_wakeup.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_sleep_wakeup;
  localparam int BASE = 20;
  localparam int OSTC = 8;
  localparam int DIV = 4;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0;
  logic [11:0] s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1;
  logic s_axi_rready = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic rc_tick, device_reset, osc_run, core_stall, prefetch_next, resume_pulse, irq_vector;
  logic watchdog_fuse_enable = 1'h1;
  logic osc_mode_rc = 1'h0;
  logic master_clear_pin_n = 1'h1;
  logic clear_watchdog_instr = 1'h0;
  logic sleep_instr = 1'h0;
  logic ext_interrupt_evt = 1'h0;
  logic port_change_evt = 1'h0;
  logic timer_overflow_evt = 1'h0;
  logic comparator_evt = 1'h0;
  logic [12:0] port_out_core = 13'h0A5A;
  logic [12:0] port_oe_core = 13'h1F0F;
  logic [12:0] port_out, port_oe;
  int failures = 0;
  int cmp_count = 0;
  wds_watchdog_sleep #(.WDT_BASE_TICKS(BASE), .OST_CYCLES(OSTC)) i_dut (.*);
  wds_core_model #(.TICK_DIV(DIV)) i_core (.aclk(aclk), .rc_tick(rc_tick));
  always #5 aclk = ~aclk;
  ////////////////////////////////////////
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 50);
    if (n >= 50) begin
      chk(32'h0, 32'h1);
      give_verdict();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [1:0] er, input logic [7:0] ed);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 50);
    if (!s_axi_rvalid) begin
      chk(32'h0, 32'h1);
      give_verdict();
    end
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    chk(s_axi_rdata, {24'h0, ed});
  endtask
  // Bounded wait on resume (0) or device reset (1); a hang ends the run
  task automatic wait_on(input int which, input int lim, output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!(which ? device_reset : resume_pulse) && n < lim);
    if (!(which ? device_reset : resume_pulse)) begin
      chk(32'h0, 32'h1);
      give_verdict();
    end
  endtask
  task automatic do_sleep;
    sleep_instr <= 1'h1;
    @(posedge aclk);
    sleep_instr <= 1'h0;
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    rd(12'h204, 2'h0, 8'hFF);
    rd(12'h20C, 2'h0, 8'h18);
    rd(12'h030, 2'h0, 8'h00);
    rd(12'h230, 2'h0, 8'h00);
    rd(12'h02C, 2'h0, 8'h00);
    wr(12'h20C, 8'h00);
    rd(12'h20C, 2'h0, 8'h18);
    rd(12'h100, 2'h2, 8'h00);
  endtask
  // Prescaler on watchdog at 1:1 and 1:2, then handed to the timer
  task automatic t_timeout;
    int n;
    int r;
    logic [7:0] opt [3] = '{8'h08, 8'h09, 8'h07};
    for (int i = 0; i < 3; i++) begin
      r = (i == 1) ? 2 : 1;
      wr(12'h204, opt[i]);
      clear_watchdog_instr <= 1'h1;
      @(posedge aclk);
      clear_watchdog_instr <= 1'h0;
      wait_on(1, 400, n);
      chk({31'h0, n >= (BASE*r-1)*DIV && n <= (BASE*r+1)*DIV+4}, 32'h1);
      rd(12'h20C, 2'h0, 8'h08);
    end
  endtask
  task automatic t_wdt_wake;
    int n;
    wr(12'h204, 8'h08);
    do_sleep();
    @(posedge aclk);
    chk({29'h0, core_stall, osc_run, prefetch_next}, 32'h5);
    port_out_core <= 13'h15A5;
    port_oe_core <= 13'h00F0;
    rd(12'h20C, 2'h0, 8'h10);
    wait_on(0, 400, n);
    chk({6'h0, port_out, port_oe}, {6'h0, 13'h0A5A, 13'h1F0F});
    chk({30'h0, irq_vector, device_reset}, 32'h0);
    rd(12'h20C, 2'h0, 8'h00);
    wait_on(1, 400, n);
    chk({31'h0, n >= (BASE-2)*DIV}, 32'h1);
  endtask
  task automatic t_irq_wake;
    int n;
    wr(12'h02C, 8'h90);
    do_sleep();
    ext_interrupt_evt <= 1'h1;
    @(posedge aclk);
    ext_interrupt_evt <= 1'h0;
    wait_on(0, 100, n);
    chk({30'h0, irq_vector, n >= OSTC}, 32'h3);
    rd(12'h02C, 2'h0, 8'h12);
  endtask
  // Fuse off and change enable off: nothing may wake the core
  task automatic t_no_wake;
    int n;
    watchdog_fuse_enable <= 1'h0;
    wr(12'h02C, 8'h80);
    do_sleep();
    port_change_evt <= 1'h1;
    @(posedge aclk);
    port_change_evt <= 1'h0;
    repeat (300) @(posedge aclk);
    chk({30'h0, core_stall, osc_run}, 32'h2);
    rd(12'h02C, 2'h0, 8'h81);
    master_clear_pin_n <= 1'h0;
    wait_on(1, 10, n);
    master_clear_pin_n <= 1'h1;
    watchdog_fuse_enable <= 1'h1;
  endtask
  task automatic t_pending;
    int n;
    wr(12'h02C, 8'h09);
    do_sleep();
    wait_on(0, 4, n);
    chk({31'h0, irq_vector}, 32'h0);
    wr(12'h02C, 8'h00);
  endtask
  task automatic t_rc_wake;
    int n;
    osc_mode_rc <= 1'h1;
    wr(12'h02C, 8'h40);
    wr(12'h230, 8'h40);
    do_sleep();
    comparator_evt <= 1'h1;
    @(posedge aclk);
    comparator_evt <= 1'h0;
    wait_on(0, 6, n);
    rd(12'h030, 2'h0, 8'h40);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs();
    t_timeout();
    t_wdt_wake();
    t_irq_wake();
    t_no_wake();
    t_pending();
    t_rc_wake();
    give_verdict();
  end
endmodule // tb_watchdog_sleep_wakeup
`default_nettype wire
